//--- logic/dtc_top.sv
// What this block does
// - Timer function counts every peripheral tick while enabled
// - Pin sampled per machine cycle, high-then-low counts
// - Count updates in following machine cycle
// - Edge recognition takes two machine cycles
// - Source select bit picks clock or pin
// - Three-bit mode from both mode registers
// - Gate bit requires gate pin high
// - Mode 000 uses 5-bit prescaler
// - Mode 001 is one 16-bit counter
// - Mode 010 reloads low from high
// - Mode 011 splits unit 0 in two
// - Unit 1 in mode 011 stops
// - Overflow inverts count pin when enabled
// - Mode 000 counter is 13 bits
// - Mode 110 is 256-tick PWM
// - Overflow sets flag, software clears it, except in mode 110, where the PWM compare sets and clears it
// - Toggle enable per unit, starts high, clock source
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module dtc_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [1:0] count_pin_in,
   output logic [1:0] count_pin_out,
   output logic [1:0] count_pin_oe_out,
   input wire logic [1:0] gate_input_pin_in,
   output logic [1:0] overflow_flag_out
);
   logic [7:0] timer_mode_control;
   logic [1:0] aux_m2;
   logic [1:0] run_control;
   logic [1:0] overflow_flag;
   logic [1:0] toggle_enable;
   logic [1:0] toggle_level;
   logic tick;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_strb_q;
   logic [1:0] gate_level;
   logic [1:0] pin_fall;
   logic [1:0] ovf_evt;
   logic [1:0] hi_ovf;
   logic [1:0] pwm_upd;
   logic [1:0] pwm_val;
   logic [1:0] unit_inc;
   logic [1:0] unit_en;
   logic [1:0] flag_set;
   logic [1:0] next_ovf;
   logic [1:0] next_tog;
   logic [7:0] tl_v [2];
   logic [7:0] th_v [2];
   logic [2:0] mode_v [2];
   logic [7:0] rd_val;

   // Write path: address and data may arrive in either order
   wire wr_fire = aw_held & w_held & ~s_axi_bvalid_out;
   wire wr_en = wr_fire & w_strb_q;
   wire wr_run = wr_en & (aw_addr_q == dtc_pkg::A_RUN);
   wire wr_mode = wr_en & (aw_addr_q == dtc_pkg::A_MODE);
   wire wr_tog = wr_en & (aw_addr_q == dtc_pkg::A_TOG);
   wire wr_aux = wr_en & (aw_addr_q == dtc_pkg::A_AUX);
   wire wr_cnt = (aw_addr_q >= dtc_pkg::A_TL0) && (aw_addr_q < dtc_pkg::A_TOG)
      && (aw_addr_q[1:0] == 2'h0);
   wire wr_map = (aw_addr_q == dtc_pkg::A_RUN) | (aw_addr_q == dtc_pkg::A_MODE)
      | (aw_addr_q == dtc_pkg::A_TOG) | (aw_addr_q == dtc_pkg::A_AUX) | wr_cnt;
   wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
   wire [11:0] ra = s_axi_araddr_in;
   wire rd_cnt = (ra >= dtc_pkg::A_TL0) && (ra < dtc_pkg::A_TOG) && (ra[1:0] == 2'h0);
   wire rd_map = (ra == dtc_pkg::A_RUN) | (ra == dtc_pkg::A_MODE)
      | (ra == dtc_pkg::A_TOG) | (ra == dtc_pkg::A_AUX) | rd_cnt;

   assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
   assign s_axi_wready_out = ~w_held & ~s_axi_bvalid_out;
   assign s_axi_arready_out = ~s_axi_rvalid_out;
   assign overflow_flag_out = overflow_flag;

   assign rd_val = (ra == dtc_pkg::A_RUN) ? {overflow_flag[1], run_control[1],
                     overflow_flag[0], run_control[0], 4'h0} :
                   (ra == dtc_pkg::A_MODE) ? timer_mode_control :
                   (ra == dtc_pkg::A_TOG) ? {6'h00, toggle_enable} :
                   (ra == dtc_pkg::A_AUX) ? {3'h0, aux_m2[1], 3'h0, aux_m2[0]} :
                   (ra == dtc_pkg::A_TL0) ? tl_v[0] :
                   (ra == dtc_pkg::A_TL0 + dtc_pkg::A_UNIT_STEP) ? tl_v[1] :
                   (ra == dtc_pkg::A_TH0) ? th_v[0] :
                   (ra == dtc_pkg::A_TH0 + dtc_pkg::A_UNIT_STEP) ? th_v[1] : 8'h00;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= dtc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata_in[7:0];
            w_strb_q <= s_axi_wstrb_in[0];
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_map ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= dtc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h00_0000, rd_val};
         s_axi_rresp_out <= rd_map ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // Machine cycle strobe, shared by timer ticks and pin sampling
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
      end
   end

   // Control registers and flags
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         next_ovf[n] = wr_run ? w_data_q[dtc_pkg::OVF_B + dtc_pkg::RUN_STRIDE * n]
                              : overflow_flag[n];
         if (pwm_upd[n]) begin
            next_ovf[n] = pwm_val[n];
         end
         next_ovf[n] = next_ovf[n] | flag_set[n];
         next_tog[n] = toggle_enable[n] ? (toggle_level[n] ^ flag_set[n]) : 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_mode_control <= dtc_pkg::MODE_RST;
         aux_m2 <= dtc_pkg::AUX_RST;
         run_control <= 2'h0;
         toggle_enable <= 2'h0;
         overflow_flag <= 2'h0;
         toggle_level <= 2'h3;
      end else begin
         if (wr_mode) begin
            timer_mode_control <= w_data_q;
         end
         if (wr_aux) begin
            aux_m2 <= {w_data_q[dtc_pkg::AUX_M2_B + dtc_pkg::MODE_STRIDE],
                       w_data_q[dtc_pkg::AUX_M2_B]};
         end
         if (wr_run) begin
            run_control <= {w_data_q[dtc_pkg::RUN_B + dtc_pkg::RUN_STRIDE],
                            w_data_q[dtc_pkg::RUN_B]};
         end
         if (wr_tog) begin
            toggle_enable <= {w_data_q[dtc_pkg::TOG_B + 1], w_data_q[dtc_pkg::TOG_B]};
         end
         overflow_flag <= next_ovf;
         toggle_level <= next_tog;
      end
   end

   // Split mode: the upper half of unit 0 reports through flag 1
   assign flag_set = {ovf_evt[1] | hi_ovf[0], ovf_evt[0]};

   for (genvar n = 0; n < 2; n++) begin : g_unit
      localparam int MB = dtc_pkg::MODE_STRIDE * n;
      logic [7:0] tl;
      logic [7:0] th;
      logic [7:0] next_tl;
      logic [7:0] next_th;
      logic [15:0] wide;
      logic l_ovf;
      logic l_hi;
      logic l_upd;
      logic l_val;
      wire [2:0] mode = {aux_m2[n], timer_mode_control[MB + dtc_pkg::MODE_B1],
                         timer_mode_control[MB + dtc_pkg::MODE_B0]};
      wire csel = timer_mode_control[MB + dtc_pkg::CSEL_B];
      wire gate = timer_mode_control[MB + dtc_pkg::GATE_B];
      wire stop = (n == 1) && (mode == dtc_pkg::M_SPLIT);
      wire hi_inc = (n == 0) && (mode == dtc_pkg::M_SPLIT) && tick && run_control[1];
      wire wr_tl = wr_en && (aw_addr_q == dtc_pkg::A_TL0 + 12'(4 * n));
      wire wr_th = wr_en && (aw_addr_q == dtc_pkg::A_TH0 + 12'(4 * n));

      dtc_pin_sync u_cnt (
         .clk_in(clk_in),
         .rst_n_in(rst_n_in),
         .pin_in(count_pin_in[n]),
         .sample_in(tick),
         .level_out(),
         .fall_out(pin_fall[n])
      );
      dtc_pin_sync u_gate (
         .clk_in(clk_in),
         .rst_n_in(rst_n_in),
         .pin_in(gate_input_pin_in[n]),
         .sample_in(tick),
         .level_out(gate_level[n]),
         .fall_out()
      );

      assign unit_en[n] = run_control[n] & (~gate | gate_level[n]) & ~stop;
      assign unit_inc[n] = unit_en[n] & (csel ? pin_fall[n] : tick);
      assign wide = {th, tl} + 16'h0001;

      always_comb begin
         next_tl = tl;
         next_th = th;
         l_ovf = 1'b0;
         l_hi = 1'b0;
         l_upd = 1'b0;
         l_val = 1'b0;
         if (unit_inc[n]) begin
            case (mode)
               dtc_pkg::M_PRESCALE: begin
                  next_tl[4:0] = tl[4:0] + 5'h01;
                  if (tl[4:0] == dtc_pkg::PRESCALE_TOP) begin
                     next_th = th + 8'h01;
                     l_ovf = (th == dtc_pkg::BYTE_TOP);
                  end
               end
               dtc_pkg::M_WIDE: begin
                  {next_th, next_tl} = wide;
                  l_ovf = ({th, tl} == 16'hffff);
               end
               dtc_pkg::M_RELOAD: begin
                  next_tl = (tl == dtc_pkg::BYTE_TOP) ? th : tl + 8'h01;
                  l_ovf = (tl == dtc_pkg::BYTE_TOP);
               end
               dtc_pkg::M_SPLIT: begin
                  next_tl = tl + 8'h01;
                  l_ovf = (tl == dtc_pkg::BYTE_TOP);
               end
               dtc_pkg::M_PWM: begin
                  next_tl = tl + 8'h01;
                  l_upd = 1'b1;
                  l_val = (next_tl >= th) && (th != dtc_pkg::BYTE_TOP);
               end
               default: begin
               end
            endcase
         end
         if (hi_inc) begin
            next_th = th + 8'h01;
            l_hi = (th == dtc_pkg::BYTE_TOP);
         end
         if (wr_tl) begin
            next_tl = w_data_q;
         end
         if (wr_th) begin
            next_th = w_data_q;
         end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            tl <= dtc_pkg::CNT_RST;
            th <= dtc_pkg::CNT_RST;
         end else begin
            tl <= next_tl;
            th <= next_th;
         end
      end

      assign tl_v[n] = tl;
      assign th_v[n] = th;
      assign mode_v[n] = mode;
      assign ovf_evt[n] = l_ovf;
      assign hi_ovf[n] = l_hi;
      assign pwm_upd[n] = l_upd;
      assign pwm_val[n] = l_val;
      // Pin drives only with the clock as source
      assign count_pin_out[n] = (mode == dtc_pkg::M_PWM) ? overflow_flag[n] : toggle_level[n];
      assign count_pin_oe_out[n] = ~csel & (toggle_enable[n] | (mode == dtc_pkg::M_PWM));
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_tick_pair;
      tick ##1 !tick ##1 tick;
   endsequence
   property p_tick_rate;
      tick |-> s_tick_pair;
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("tick not every 2 clocks");

   wire csel0_w = timer_mode_control[dtc_pkg::CSEL_B];
   property p_timer_wide;
      (unit_inc[0] && !csel0_w && mode_v[0] == dtc_pkg::M_WIDE && !wr_en)
         |=> ({th_v[0], tl_v[0]} == $past({th_v[0], tl_v[0]}) + 16'h0001);
   endproperty
   a_timer_wide: assert property (p_timer_wide) else $error("16-bit count wrong");

   property p_pin_only;
      (csel0_w && !pin_fall[0]) |-> !unit_inc[0];
   endproperty
   a_pin_only: assert property (p_pin_only) else $error("counted without pin edge");

   property p_gate;
      (timer_mode_control[dtc_pkg::GATE_B] && !gate_level[0]) |-> !unit_en[0];
   endproperty
   a_gate: assert property (p_gate) else $error("gate ignored");

   property p_prescale;
      (unit_inc[0] && mode_v[0] == dtc_pkg::M_PRESCALE && tl_v[0][4:0] == 5'h1f && !wr_en)
         |=> (tl_v[0][4:0] == 5'h00) && (th_v[0] == $past(th_v[0]) + 8'h01);
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler carry wrong");

   sequence s_reload_done;
      (tl_v[0] == $past(th_v[0])) && overflow_flag[0];
   endsequence
   property p_reload;
      (unit_inc[0] && mode_v[0] == dtc_pkg::M_RELOAD && tl_v[0] == 8'hff && !wr_en)
         |=> s_reload_done;
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");

   property p_unit1_stop;
      (mode_v[1] == dtc_pkg::M_SPLIT) |-> !unit_inc[1];
   endproperty
   a_unit1_stop: assert property (p_unit1_stop) else $error("unit 1 ran in split mode");

   property p_toggle;
      (flag_set[0] && toggle_enable[0] && mode_v[0] != dtc_pkg::M_PWM && !wr_tog)
         |=> (count_pin_out[0] != $past(count_pin_out[0]));
   endproperty
   a_toggle: assert property (p_toggle) else $error("pin not toggled");

   property p_flag_set;
      flag_set[1] |=> overflow_flag[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag lost");
endmodule : dtc_top

//--- logic/dtc_pkg.sv
package dtc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RUN = 8'h88;
   localparam logic [7:0] IDX_MODE = 8'h89;
   localparam logic [7:0] IDX_TL0 = 8'h8a;
   localparam logic [7:0] IDX_TH0 = 8'h8c;
   localparam logic [7:0] IDX_TOG = 8'h8e;
   localparam logic [7:0] IDX_AUX = 8'h8f;
   localparam logic [11:0] A_RUN = {2'h0, IDX_RUN, 2'h0};
   localparam logic [11:0] A_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] A_TL0 = {2'h0, IDX_TL0, 2'h0};
   localparam logic [11:0] A_TH0 = {2'h0, IDX_TH0, 2'h0};
   localparam logic [11:0] A_TOG = {2'h0, IDX_TOG, 2'h0};
   localparam logic [11:0] A_AUX = {2'h0, IDX_AUX, 2'h0};
   localparam logic [11:0] A_UNIT_STEP = 12'h004;
   // Field positions; unit 1 sits at the unit stride above unit 0
   localparam int MODE_STRIDE = 4;
   localparam int MODE_B0 = 0;
   localparam int MODE_B1 = 1;
   localparam int CSEL_B = 2;
   localparam int GATE_B = 3;
   localparam int AUX_M2_B = 0;
   localparam int RUN_B = 4;
   localparam int OVF_B = 5;
   localparam int RUN_STRIDE = 2;
   localparam int TOG_B = 0;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [1:0] AUX_RST = 2'h0;
   localparam logic [7:0] CNT_RST = 8'h00;
   // Mode codes
   localparam logic [2:0] M_PRESCALE = 3'h0;
   localparam logic [2:0] M_WIDE = 3'h1;
   localparam logic [2:0] M_RELOAD = 3'h2;
   localparam logic [2:0] M_SPLIT = 3'h3;
   localparam logic [2:0] M_PWM = 3'h6;
   localparam logic [4:0] PRESCALE_TOP = 5'h1f;
   localparam logic [7:0] BYTE_TOP = 8'hff;
   // Timing
   localparam int CLK_NS = 50;
   localparam int MACHINE_CYCLE_NS = 100;
   localparam int MC_CLOCKS = MACHINE_CYCLE_NS / CLK_NS;
   localparam int EDGE_MIN_CLOCKS = 2 * MC_CLOCKS;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtc_pkg

//--- logic/dtc_pin_sync.sv
`timescale 1ns/1ps
module dtc_pin_sync (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic sample_in,
   output logic level_out,
   output logic fall_out
);
   logic s1;
   logic s2;
   logic s3;
   logic last;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         level_out <= 1'b1;
         last <= 1'b1;
         fall_out <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level_out <= s3;
         end
         if (sample_in) begin
            last <= level_out;
         end
         fall_out <= sample_in & last & ~level_out;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_fall_seen;
      (sample_in && last && !level_out) |=> fall_out;
   endproperty
   a_fall_seen: assert property (p_fall_seen) else $error("missed falling sample");

   property p_fall_spacing;
      fall_out |=> !fall_out [*3];
   endproperty
   a_fall_spacing: assert property (p_fall_spacing) else $error("edges closer than 4 clocks");
endmodule : dtc_pin_sync

//--- testbench/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model (
   input wire logic clk_in,
   input wire logic [1:0] oe_in,
   input wire logic [1:0] drv_in,
   output logic [1:0] count_pin_out,
   output logic [1:0] gate_pin_out
);
   logic [1:0] src;
   initial begin
      src = 2'h3;
      gate_pin_out = 2'h0;
   end
   // Wire level: the block wins while it drives
   assign count_pin_out = (oe_in & drv_in) | (~oe_in & src);
   // Each level held at least one machine cycle
   task automatic pulses(input int u, input int n, input int hold);
      repeat (n) begin
         repeat (hold) @(posedge clk_in);
         src[u] <= 1'b0;
         repeat (hold) @(posedge clk_in);
         src[u] <= 1'b1;
      end
      repeat (8) @(posedge clk_in);
   endtask : pulses
   task automatic gate(input int u, input logic v);
      @(posedge clk_in);
      gate_pin_out[u] <= v;
   endtask : gate
endmodule : dtc_pin_model

//--- testbench/dual_timer_counter_modes_test.sv
`timescale 1ns/1ps
module dual_timer_counter_modes_test;
   localparam logic [11:0] A_TL1 = dtc_pkg::A_TL0 + dtc_pkg::A_UNIT_STEP;
   localparam logic [11:0] A_TH1 = dtc_pkg::A_TH0 + dtc_pkg::A_UNIT_STEP;
   localparam int HOLD = dtc_pkg::MC_CLOCKS;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, pin, pout, poe, gate, flag;
   logic [7:0] d;
   int err_total, cmp_count, cyc, n;

   dtc_top uut (.clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .count_pin_in(pin), .count_pin_out(pout),
      .count_pin_oe_out(poe), .gate_input_pin_in(gate), .overflow_flag_out(flag));

   dtc_pin_model pm (.clk_in(clk), .oe_in(poe), .drv_in(pout), .count_pin_out(pin),
      .gate_pin_out(gate));

   always #25 clk = ~clk;

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata[7:0];
      resp = rresp;
   endtask : rd

   task automatic wait_flag(input int u, input int lim);
      n = 0;
      while (flag[u] !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(32'(flag[u]), 32'h1);
   endtask : wait_flag

   task automatic preload(input logic [7:0] m, input logic [7:0] hi, input logic [7:0] lo);
      wr(dtc_pkg::A_MODE, m);
      wr(dtc_pkg::A_TH0, hi);
      wr(dtc_pkg::A_TL0, lo);
   endtask : preload

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {awvalid, wvalid, arvalid} = 3'h0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'h1;
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(dtc_pkg::A_MODE);
      chk(32'(d), 32'(dtc_pkg::MODE_RST));
      rd(dtc_pkg::A_AUX);
      chk(32'(d), 32'h0);
      chk(32'(pout), 32'h3);
      chk(32'(flag), 32'h0);
      rd(12'h000);
      chk(32'(resp), 32'(dtc_pkg::RESP_SLVERR));
      wr(12'h000, 8'h55);
      chk(32'(resp), 32'(dtc_pkg::RESP_SLVERR));
      wr(dtc_pkg::A_AUX, 8'hee);
      rd(dtc_pkg::A_AUX);
      chk(32'(d), 32'h0);
      // Only documented mode codes are written
      wr(dtc_pkg::A_MODE, 8'h22);
      wr(dtc_pkg::A_AUX, 8'h11);
      rd(dtc_pkg::A_AUX);
      chk(32'(d), 32'h11);
      wr(dtc_pkg::A_AUX, 8'h00);
      // 13-bit mode: low five bits roll into high byte at once
      preload(8'h00, 8'hff, 8'h1f);
      wr(dtc_pkg::A_RUN, 8'h10);
      wait_flag(0, 20);
      wr(dtc_pkg::A_RUN, 8'h00);
      rd(dtc_pkg::A_TH0);
      chk(32'(d), 32'h0);
      rd(dtc_pkg::A_TL0);
      chk(32'(d[4:0] < 5'h10), 32'h1);
      chk(32'(flag[0]), 32'h0);
      // 16-bit mode: same preload needs 225 ticks
      preload(8'h01, 8'hff, 8'h1f);
      wr(dtc_pkg::A_RUN, 8'h10);
      repeat (20) @(posedge clk);
      chk(32'(flag[0]), 32'h0);
      wait_flag(0, 500);
      wr(dtc_pkg::A_RUN, 8'h00);
      rd(dtc_pkg::A_TH0);
      chk(32'(d), 32'h0);
      // Auto reload keeps the high byte
      preload(8'h02, 8'hf0, 8'hfe);
      wr(dtc_pkg::A_RUN, 8'h10);
      wait_flag(0, 20);
      wr(dtc_pkg::A_RUN, 8'h00);
      rd(dtc_pkg::A_TH0);
      chk(32'(d), 32'hf0);
      rd(dtc_pkg::A_TL0);
      chk(32'(d >= 8'hf0), 32'h1);
      // Toggle output: one overflow per 256 ticks
      preload(8'h02, 8'h00, 8'h00);
      wr(dtc_pkg::A_TOG, 8'h01);
      chk(32'({poe[0], pout[0]}), 32'h3);
      wr(dtc_pkg::A_RUN, 8'h10);
      n = 0;
      while (pout[0] !== 1'b0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (pout[0] !== 1'b1 && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n), 32'(256 * dtc_pkg::MC_CLOCKS));
      wr(dtc_pkg::A_RUN, 8'h00);
      wr(dtc_pkg::A_TOG, 8'h00);
      // Pulse width: flag high for 256 minus high byte ticks
      wr(dtc_pkg::A_AUX, 8'h01);
      preload(8'h02, 8'h40, 8'h00);
      wr(dtc_pkg::A_RUN, 8'h10);
      repeat (20) @(posedge clk);
      chk(32'(poe[0]), 32'h1);
      n = 0;
      repeat (256 * dtc_pkg::MC_CLOCKS) begin
         @(posedge clk);
         if (flag[0] === 1'b1)
            n++;
      end
      chk(32'(n), 32'((256 - 8'h40) * dtc_pkg::MC_CLOCKS));
      wr(dtc_pkg::A_RUN, 8'h00);
      wr(dtc_pkg::A_AUX, 8'h00);
      // Split: high byte runs on unit 1 controls
      preload(8'h03, 8'hfe, 8'h00);
      wr(dtc_pkg::A_RUN, 8'h40);
      wait_flag(1, 20);
      wr(dtc_pkg::A_RUN, 8'h00);
      rd(dtc_pkg::A_TL0);
      chk(32'(d), 32'h0);
      // Unit 1 in split code stands still
      wr(dtc_pkg::A_MODE, 8'h30);
      wr(A_TL1, 8'hf0);
      wr(A_TH1, 8'hff);
      wr(dtc_pkg::A_RUN, 8'h40);
      repeat (60) @(posedge clk);
      chk(32'(flag[1]), 32'h0);
      wr(dtc_pkg::A_RUN, 8'h00);
      rd(A_TL1);
      chk(32'(d), 32'hf0);
      // Event counting at full and slow rate
      preload(8'h05, 8'h00, 8'h00);
      wr(dtc_pkg::A_RUN, 8'h10);
      pm.pulses(0, 5, HOLD);
      rd(dtc_pkg::A_TL0);
      chk(32'(d), 32'h5);
      pm.pulses(0, 3, 3 * HOLD);
      rd(dtc_pkg::A_TL0);
      chk(32'(d), 32'h8);
      wr(dtc_pkg::A_MODE, 8'h50);
      wr(A_TL1, 8'h00);
      wr(dtc_pkg::A_RUN, 8'h40);
      pm.pulses(1, 2, 3);
      rd(A_TL1);
      chk(32'(d), 32'h2);
      // Gated counting follows the gate pin
      preload(8'h0d, 8'h00, 8'h00);
      wr(dtc_pkg::A_RUN, 8'h10);
      pm.pulses(0, 3, 3);
      rd(dtc_pkg::A_TL0);
      chk(32'(d), 32'h0);
      pm.gate(0, 1'b1);
      pm.pulses(0, 3, 3);
      rd(dtc_pkg::A_TL0);
      chk(32'(d), 32'h3);
      wr(dtc_pkg::A_RUN, 8'h00);
      print_verdict();
   end
endmodule : dual_timer_counter_modes_test
